/* bench/stored_waveform_display_list_tb_top.sv */
// Self-checking bench for the stored-waveform display list top.
// Assumes the far-side model file and the bound checker are compiled with it.
`include "swd_defines.svh"
module stored_waveform_display_list_tb_top
  import swd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    swd_cmd_t    cmd;
    logic [15:0] x;
    logic        warn;
  } swd_row_t;
  localparam logic [7:0]  OPER = 8'h11;
  localparam logic [15:0] HINC = 16'h0003;
  localparam logic [15:0] TSCL = 16'h0250;
  logic                clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, slow = 1'b1;
  swd_cmd_t            cmd_code = SWD_CMD_CLEAR;
  logic signed [15:0]  stack_x = 16'h0000;
  logic                ax, vc;
  logic [7:0]          src;
  logic [63:0]         inl;
  int                  mismatches = 0, n_compared = 0;
  wire logic           cmd_ready, stack_pop, warn, mem_rd, draw_valid, draw_ready, draw_vec, vec_mode, axis_mode;
  wire logic [7:0]     mem_wfm;
  wire logic [8:0]     mem_pt;
  wire logic signed [15:0] mem_data, draw_x0, draw_y0, draw_x1, draw_y1;
  wire logic [15:0]    mem_vscale, hscale;
  wire swd_line_t      line2_mnem;
  wire logic [3:0]     line2_count;
  wire logic [71:0]    line2_nums;
  swd_row_t rows [16] = '{
    '{SWD_CMD_ADD,    16'h0050, 1'b0},
    '{SWD_CMD_ADD,    16'h0050, 1'b0},
    '{SWD_CMD_ADD,    16'h03F0, 1'b0},
    '{SWD_CMD_ADD,    16'h0038, 1'b0},
    '{SWD_CMD_ADD,    16'h0400, 1'b1},
    '{SWD_CMD_ADD,    16'hFFF0, 1'b1},
    '{SWD_CMD_REMOVE, 16'h0090, 1'b1},
    '{SWD_CMD_REMOVE, 16'h0050, 1'b0},
    '{SWD_CMD_VECTOR, 16'h0000, 1'b0},
    '{SWD_CMD_AXIS,   16'h0020, 1'b0},
    '{SWD_CMD_ADD,    16'h0070, 1'b0},
    '{SWD_CMD_DOT,    16'h0000, 1'b0},
    '{SWD_CMD_AXIS,   16'h0410, 1'b1},
    '{SWD_CMD_TIME,   16'h0000, 1'b0},
    '{SWD_CMD_ADD,    16'h0110, 1'b0},
    '{SWD_CMD_CLEAR,  16'h0000, 1'b0}
  };

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  swd_top dut (
    .CORE_CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_READY(cmd_ready),
    .STACK_X(stack_x), .STACK_POP(stack_pop), .WARN(warn), .OPER_WFM(OPER), .TIME_HINC(HINC),
    .TIME_HSCALE(TSCL), .MEM_RD(mem_rd), .MEM_WFM(mem_wfm), .MEM_PT(mem_pt), .MEM_DATA(mem_data),
    .MEM_VSCALE(mem_vscale), .DRAW_VALID(draw_valid), .DRAW_READY(draw_ready), .DRAW_VEC(draw_vec),
    .DRAW_X0(draw_x0), .DRAW_Y0(draw_y0), .DRAW_X1(draw_x1), .DRAW_Y1(draw_y1), .HSCALE(hscale),
    .LINE2_MNEM(line2_mnem), .LINE2_COUNT(line2_count), .LINE2_NUMS(line2_nums), .VEC_MODE(vec_mode),
    .AXIS_MODE(axis_mode)
  );

  swd_far_model u_far (
    .clk(clk), .slow(slow), .mem_rd(mem_rd), .mem_wfm(mem_wfm), .mem_pt(mem_pt),
    .mem_data(mem_data), .mem_vscale(mem_vscale), .draw_ready(draw_ready)
  );

  task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reference model of the list and the two mode pairs.
  task apply(input swd_cmd_t c, input logic signed [15:0] x);
    int   w;
    logic ok;
    w  = (int'(x) + 8) >>> 4;
    ok = w >= 0 && w <= 63;
    case (c)
      SWD_CMD_CLEAR:  inl = '0;
      SWD_CMD_REMOVE: if (ok) inl[w] = 1'b0;
      SWD_CMD_ADD:    if (ok && $countones(inl) < 8) inl[w] = 1'b1;
      SWD_CMD_AXIS:   if (ok) begin
        ax  = 1'b1;
        src = w[7:0];
      end
      SWD_CMD_TIME:   ax = 1'b0;
      SWD_CMD_DOT:    vc = 1'b0;
      default:        vc = 1'b1;
    endcase
  endtask

  task wait_ready;
    for (int i = 0; i < 8000 && cmd_ready !== 1'b1; i++) @(negedge clk);
    chk("cmd_ready", 72'h1, cmd_ready);
  endtask

  // Higher first point sorts left; first points equal the address shifted up.
  task check_state;
    logic [71:0] nums;
    int          n;
    nums = '0;
    n    = 0;
    @(negedge clk);
    for (int w = 63; w >= 0; w--)
      if (ax ? w == src : (inl[w] || w == OPER)) begin
        nums[n*8 +: 8] = w[7:0];
        n++;
      end
    chk("line2_nums", nums, line2_nums);
    chk("line2_count", n, line2_count);
    chk("line2_mnem", ax, line2_mnem);
    chk("axis_mode", ax, axis_mode);
    chk("vec_mode", vc, vec_mode);
    chk("hscale", ax ? 16'h0100 + 16'(src) : TSCL, hscale);
  endtask

  task run(input swd_cmd_t c, input logic signed [15:0] x, input logic ew);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    stack_x   = x;
    wait_ready();
    @(posedge clk);
    apply(c, x);
    @(negedge clk);
    cmd_valid = 1'b0;
    chk("stack_pop", c inside {SWD_CMD_REMOVE, SWD_CMD_ADD, SWD_CMD_AXIS}, stack_pop);
    chk("warn", ew, warn);
    wait_ready();
    check_state();
  endtask

  task do_reset;
    @(negedge clk);
    resetn = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    inl = '0;
    ax  = 1'b0;
    vc  = 1'b0;
    src = 8'h00;
    wait_ready();
    check_state();
  endtask
  task conclude;
    if (mismatches == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Every taken draw item is checked against the current drawing and axis modes.
  always @(negedge clk) begin
    if (resetn && draw_valid === 1'b1 && draw_ready === 1'b1) begin
      chk("draw_vec", vc, draw_vec);
      if (vc)
        chk("draw_y1", draw_y0 + 16'sh0001, draw_y1);
      chk("draw_x0", ax ? {src[6:0], draw_y0[8:0]} : 16'(draw_y0[8:0]) * HINC, draw_x0);
    end
  end

  // The run needs under about 90000 cycles at worst.
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // Row table with a slow display, then a full list, a final reset and the end.
  initial begin
    do_reset();
    foreach (rows[i])
      run(rows[i].cmd, rows[i].x, rows[i].warn);
    slow = 1'b0;
    run(SWD_CMD_ADD, 16'hFFF8, 1'b0);
    for (int i = 20; i < 27; i++)
      run(SWD_CMD_ADD, 16'(i * 16), 1'b0);
    run(SWD_CMD_ADD, 16'h01E0, 1'b1);
    run(SWD_CMD_ADD, 16'h0110, 1'b1);
    run(SWD_CMD_REMOVE, 16'h0140, 1'b0);
    run(SWD_CMD_ADD, 16'h0110, 1'b0);
    run(SWD_CMD_CLEAR, 16'h0000, 1'b0);
    do_reset();
    conclude();
  end
endmodule // stored_waveform_display_list_tb_top

/* bench/swd_far_model.sv */
// Far-side model: waveform memory with one-cycle reads and a display sink.
// Assumes address and strobe are settled before each rising edge.
`include "swd_defines.svh"
module swd_far_model (
  input  wire logic                    clk,
  input  wire logic                    slow,
  input  wire logic                    mem_rd,
  input  wire logic [`SWD_WFM_W-1:0]   mem_wfm,
  input  wire logic [`SWD_PT_W-1:0]    mem_pt,
  output logic signed [`SWD_VAL_W-1:0] mem_data,
  output logic [`SWD_VAL_W-1:0]        mem_vscale,
  output logic                         draw_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] beat_reg = 3'h0;
  // A point reads as its address above its index; without a read the bus scrambles.
  always_ff @(posedge clk) begin
    beat_reg <= beat_reg + 3'h1;
    if (mem_rd) begin
      mem_data   <= {mem_wfm[6:0], mem_pt};
      mem_vscale <= 16'h0100 + 16'(mem_wfm);
    end else begin
      mem_data   <= ~mem_data;
      mem_vscale <= ~mem_vscale;
    end
  end
  // The slow display stalls one cycle in eight.
  assign draw_ready = !slow || beat_reg != 3'h0;
endmodule // swd_far_model

/* bench/swd_top_chk_sva.sv */
// Concurrent checks on the ports of the stored-waveform display list top.
// Assumes one clock, CORE_CLK, with RESETN synchronous and active low.
`include "swd_defines.svh"
module swd_top_chk
  import swd_pkg::*;
(
  input wire logic                         CORE_CLK,
  input wire logic                         RESETN,
  input wire logic                         CMD_VALID,
  input wire swd_cmd_t                     CMD_CODE,
  input wire logic                         CMD_READY,
  input wire logic                         STACK_POP,
  input wire logic                         WARN,
  input wire logic                         DRAW_VALID,
  input wire logic                         DRAW_READY,
  input wire logic                         DRAW_VEC,
  input wire logic signed [`SWD_VAL_W-1:0] DRAW_X0,
  input wire logic signed [`SWD_VAL_W-1:0] DRAW_Y0,
  input wire logic signed [`SWD_VAL_W-1:0] DRAW_X1,
  input wire logic signed [`SWD_VAL_W-1:0] DRAW_Y1,
  input wire swd_line_t                    LINE2_MNEM,
  input wire logic [3:0]                   LINE2_COUNT,
  input wire logic                         VEC_MODE,
  input wire logic                         AXIS_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // A taken command, and a taken command that uses the stack operand.
  wire logic acc     = CMD_VALID && CMD_READY;
  wire logic acc_pop = acc && (CMD_CODE inside {SWD_CMD_REMOVE, SWD_CMD_ADD, SWD_CMD_AXIS});

  AST_POP_AFTER_TAKE: assert property (acc_pop |=> STACK_POP) else $error("no pop after operand command");
  AST_NO_POP_OTHER: assert property (acc && !acc_pop |=> !STACK_POP && !WARN) else $error("stray pop or warn");
  AST_POP_PULSE: assert property (STACK_POP |=> !STACK_POP) else $error("pop longer than one cycle");
  AST_WARN_WITH_POP: assert property (WARN |-> STACK_POP) else $error("warn without pop");
  AST_READY_DROPS: assert property (acc |=> !CMD_READY [*8]) else $error("ready back too soon");
  AST_VEC_SEL: assert property (acc && CMD_CODE == SWD_CMD_VECTOR |=> VEC_MODE) else $error("vector not set");
  AST_DOT_SEL: assert property (acc && CMD_CODE == SWD_CMD_DOT |=> !VEC_MODE && $stable(AXIS_MODE))
    else $error("dot select wrong");
  AST_TIME_SEL: assert property (acc && CMD_CODE == SWD_CMD_TIME |=> !AXIS_MODE ##[0:40] LINE2_MNEM == SWD_LINE_LIST)
    else $error("time select wrong");
  AST_AXIS_SEL: assert property (acc && CMD_CODE == SWD_CMD_AXIS |=> WARN || AXIS_MODE)
    else $error("axis not set");
  AST_MODE_HOLD: assert property (!acc |=> $stable(VEC_MODE) && $stable(AXIS_MODE)) else $error("mode moved");
  AST_DOT_ITEM: assert property (DRAW_VALID && !DRAW_VEC |-> DRAW_X1 == DRAW_X0 && DRAW_Y1 == DRAW_Y0)
    else $error("dot item not a point");
  AST_ITEM_HOLD: assert property (DRAW_VALID && !DRAW_READY |=> DRAW_VALID && $stable(DRAW_X1) && $stable(DRAW_Y1))
    else $error("draw item dropped");
  AST_COUNT_RANGE: assert property ($past(RESETN) |-> LINE2_COUNT >= 4'h1 && LINE2_COUNT <= 4'h9)
    else $error("line count out of range");

  // Main scenarios reached.
  cover property (acc_pop ##1 WARN);
  cover property ($rose(AXIS_MODE));
  cover property (DRAW_VALID && DRAW_READY && DRAW_VEC);
  cover property (LINE2_COUNT == 4'h9);
endmodule // swd_top_chk

bind swd_top swd_top_chk u_chk (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_READY(CMD_READY),
  .STACK_POP(STACK_POP), .WARN(WARN), .DRAW_VALID(DRAW_VALID), .DRAW_READY(DRAW_READY), .DRAW_VEC(DRAW_VEC),
  .DRAW_X0(DRAW_X0), .DRAW_Y0(DRAW_Y0), .DRAW_X1(DRAW_X1), .DRAW_Y1(DRAW_Y1), .LINE2_MNEM(LINE2_MNEM),
  .LINE2_COUNT(LINE2_COUNT), .VEC_MODE(VEC_MODE), .AXIS_MODE(AXIS_MODE)
);

/* logic/swd_defines.svh */
// Constants for the stored-waveform display list block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SWD_DEFINES_SVH
`define SWD_DEFINES_SVH
`define SWD_WFM_W     8
`define SWD_MAX_WFM   16'h003F
`define SWD_LIST_N    8
`define SWD_ENT_N     9
`define SWD_SRC_IDX   4'h9
`define SWD_OPER_IDX  4'h8
`define SWD_PT_W      9
`define SWD_LAST_PT   9'h1FF
`define SWD_VAL_W     16
`define SWD_FRAC_W    4
`define SWD_HALF_LSB  16'h0008
`endif

/* logic/swd_ent_if.sv */
// Interface between the core, the list slots and the ordering units.
// Assumes one clock domain; it carries only combinational signals.
`include "swd_defines.svh"
interface swd_ent_if;
  logic                        clr_all;
  logic                        rm_stb;
  logic                        add_stb;
  logic [`SWD_WFM_W-1:0]       key;
  logic                        add_sel  [`SWD_LIST_N];
  logic                        hit      [`SWD_LIST_N];
  logic                        slot_on  [`SWD_LIST_N];
  logic [`SWD_WFM_W-1:0]       slot_wfm [`SWD_LIST_N];
  logic                        ent_on   [`SWD_ENT_N];
  logic signed [`SWD_VAL_W-1:0] ent_y   [`SWD_ENT_N];
  logic [3:0]                  rank     [`SWD_ENT_N];
  modport core (output clr_all, rm_stb, add_stb, key, add_sel, ent_on, ent_y,
                input hit, slot_on, slot_wfm, rank);
  modport slot (input clr_all, rm_stb, add_stb, key, add_sel,
                output hit, slot_on, slot_wfm);
  modport ranker (input ent_on, ent_y, output rank);
endinterface : swd_ent_if

/* logic/swd_pkg.sv */
// Types shared by the stored-waveform display list block.
// Assumes swd_defines.svh is on the include path.
package swd_pkg;
  typedef enum logic [2:0] {
    SWD_CMD_CLEAR,
    SWD_CMD_REMOVE,
    SWD_CMD_DOT,
    SWD_CMD_ADD,
    SWD_CMD_TIME,
    SWD_CMD_VECTOR,
    SWD_CMD_AXIS
  } swd_cmd_t;
  typedef enum logic {
    SWD_LINE_LIST,
    SWD_LINE_AXIS
  } swd_line_t;
endpackage : swd_pkg

/* logic/swd_rank.sv */
// Screen-order position of one displayed entry on the readout line.
// Assumes first-point values are current; higher values sit higher on screen.
`include "swd_defines.svh"
module swd_rank
  import swd_pkg::*;
#(
  parameter int IDX = 0
) (
  swd_ent_if.ranker ent
);
  logic [3:0] cnt;

  // Count the entries whose first point lies above this one; ties go by index.
  always_comb begin
    cnt = 4'h0;
    for (int j = 0; j < `SWD_ENT_N; j++) begin
      if (ent.ent_on[j] && ((ent.ent_y[j] > ent.ent_y[IDX]) ||
          ((ent.ent_y[j] == ent.ent_y[IDX]) && (j < IDX)))) begin
        cnt = cnt + 4'h1; // RULE13
      end
    end
  end

  assign ent.rank[IDX] = cnt;
endmodule // swd_rank

/* logic/swd_slot.sv */
// One entry of the display list: a valid flag and a waveform address.
// Assumes the core raises at most one strobe per cycle.
`include "swd_defines.svh"
module swd_slot
  import swd_pkg::*;
#(
  parameter int IDX = 0
) (
  input  wire logic clk,
  input  wire logic resetn,
  swd_ent_if.slot   ent
);
  logic                  on_reg;
  logic [`SWD_WFM_W-1:0] wfm_reg;

  // The slot matches when it holds the waveform named by the key.
  assign ent.hit[IDX]      = on_reg && (wfm_reg == ent.key);
  assign ent.slot_on[IDX]  = on_reg;
  assign ent.slot_wfm[IDX] = wfm_reg;

  // Clear empties every slot, remove empties the matching one only.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      on_reg  <= 1'b0;
      wfm_reg <= '0;
    end else if (ent.clr_all) begin
      on_reg <= 1'b0; // RULE1
    end else if (ent.rm_stb && ent.hit[IDX]) begin
      on_reg <= 1'b0; // RULE3
    end else if (ent.add_stb && ent.add_sel[IDX]) begin
      on_reg  <= 1'b1; // RULE7
      wfm_reg <= ent.key;
    end
  end
endmodule // swd_slot

/* logic/swd_top.sv */
// Stored-waveform display list: command handler, readout line and drawing.
// Assumes commands, stack value and memory data come from CORE_CLK logic
// and the waveform memory answers a read one cycle after it is asked.
`include "swd_defines.svh"
// Overview of operation
// RULE1: Clear empties every added list entry.
// RULE2: Operational waveform stays drawn after clear.
// RULE3: Remove deletes named added waveform, then pops.
// RULE4: Stack operand rounds into valid address range.
// RULE5: Removing a non-added waveform raises warning.
// RULE6: Dot mode draws one dot per point.
// RULE7: Add appends named waveform, others stay.
// RULE8: Adding a shown waveform makes no duplicate.
// RULE9: List holds at most eight entries.
// RULE10: Add on full list pops, warns, changes nothing.
// RULE11: Operational waveform always drawn, nine possible.
// RULE12: Readout shows list mnemonic and all numbers.
// RULE13: Numbers ordered as first points, top down.
// RULE14: Add pops the stack after use.
// RULE15: Time axis x is index times increment.
// RULE16: Vector mode joins neighbouring points with lines.
// RULE17: Axis command takes source waveform, then pops.
// RULE18: Axis mode x is source point value.
// RULE19: Axis mode readout shows source number.
// RULE20: Axis mode scale is source vertical scale.
// RULE21: Drawing and axis selections each persist exclusively.
module swd_top
  import swd_pkg::*;
(
  input  wire logic                         CORE_CLK,
  input  wire logic                         RESETN,
  input  wire logic                         CMD_VALID,
  input  wire swd_cmd_t                     CMD_CODE,
  output wire logic                         CMD_READY,
  input  wire logic signed [`SWD_VAL_W-1:0] STACK_X,
  output wire logic                         STACK_POP,
  output wire logic                         WARN,
  input  wire logic [`SWD_WFM_W-1:0]        OPER_WFM,
  input  wire logic signed [`SWD_VAL_W-1:0] TIME_HINC,
  input  wire logic [`SWD_VAL_W-1:0]        TIME_HSCALE,
  output wire logic                         MEM_RD,
  output wire logic [`SWD_WFM_W-1:0]        MEM_WFM,
  output wire logic [`SWD_PT_W-1:0]         MEM_PT,
  input  wire logic signed [`SWD_VAL_W-1:0] MEM_DATA,
  input  wire logic [`SWD_VAL_W-1:0]        MEM_VSCALE,
  output wire logic                         DRAW_VALID,
  input  wire logic                         DRAW_READY,
  output wire logic                         DRAW_VEC,
  output wire logic signed [`SWD_VAL_W-1:0] DRAW_X0,
  output wire logic signed [`SWD_VAL_W-1:0] DRAW_Y0,
  output wire logic signed [`SWD_VAL_W-1:0] DRAW_X1,
  output wire logic signed [`SWD_VAL_W-1:0] DRAW_Y1,
  output wire logic [`SWD_VAL_W-1:0]        HSCALE,
  output wire swd_line_t                    LINE2_MNEM,
  output wire logic [3:0]                   LINE2_COUNT,
  output wire logic [9*`SWD_WFM_W-1:0]      LINE2_NUMS,
  output wire logic                         VEC_MODE,
  output wire logic                         AXIS_MODE
);
  typedef enum {C_IDLE, C_RDF, C_CAPF} swd_cst_t;
  typedef enum {D_SEL, D_RDS, D_CAPS, D_RDP, D_CAPP, D_WAIT} swd_dst_t;

  swd_ent_if ent ();

  swd_cst_t                     c_st_reg;
  swd_cst_t                     c_st_next;
  swd_dst_t                     d_st_reg;
  swd_dst_t                     d_st_next;
  logic [3:0]                   r_idx_reg;
  logic                         pop_reg;
  logic                         warn_reg;
  logic                         vec_reg;
  logic                         axis_reg;
  logic [`SWD_WFM_W-1:0]        src_reg;
  logic [`SWD_VAL_W-1:0]        src_scale_reg;
  logic signed [`SWD_VAL_W-1:0] first_y_reg [`SWD_ENT_N];
  logic [3:0]                   d_ent_reg;
  logic [`SWD_PT_W-1:0]         d_pt_reg;
  logic signed [`SWD_VAL_W-1:0] src_y_reg;
  logic signed [`SWD_VAL_W-1:0] prev_x_reg;
  logic signed [`SWD_VAL_W-1:0] prev_y_reg;
  logic                         dv_reg;
  logic                         dvec_reg;
  logic signed [`SWD_VAL_W-1:0] x0_reg;
  logic signed [`SWD_VAL_W-1:0] y0_reg;
  logic signed [`SWD_VAL_W-1:0] x1_reg;
  logic signed [`SWD_VAL_W-1:0] y1_reg;
  logic [`SWD_VAL_W-1:0]        hscale_reg;
  swd_line_t                    mnem_reg;
  logic [3:0]                   count_reg;
  logic [9*`SWD_WFM_W-1:0]      nums_reg;
  logic [9*`SWD_WFM_W-1:0]      nums_next;
  logic [3:0]                   count_next;

  // Slots of the display list and the screen-order units.
  for (genvar i = 0; i < `SWD_LIST_N; i++) begin : g_slot
    swd_slot #(.IDX(i)) u_slot (
      .clk    (CORE_CLK),
      .resetn (RESETN),
      .ent    (ent)
    );
  end
  for (genvar i = 0; i < `SWD_ENT_N; i++) begin : g_rank
    swd_rank #(.IDX(i)) u_rank (
      .ent (ent)
    );
  end

  // Operand rounding and range check of the top stack entry.
  wire logic signed [`SWD_VAL_W-1:0] x_sum   = STACK_X + `SWD_HALF_LSB;
  wire logic signed [`SWD_VAL_W-1:0] x_round = x_sum >>> `SWD_FRAC_W;
  wire logic in_range = !x_round[`SWD_VAL_W-1] &&
                        (x_round <= `SWD_MAX_WFM); // RULE4

  // List summary: any slot naming the operand, all slots busy.
  logic any_hit;
  logic full;
  logic oper_in;
  always_comb begin
    any_hit = 1'b0;
    full    = 1'b1;
    oper_in = 1'b0;
    for (int i = 0; i < `SWD_LIST_N; i++) begin
      any_hit = any_hit | ent.hit[i];
      full    = full & ent.slot_on[i]; // RULE9
      oper_in = oper_in | (ent.slot_on[i] && (ent.slot_wfm[i] == OPER_WFM));
    end
  end

  // First free slot takes a new waveform.
  always_comb begin
    logic found;
    found = 1'b0;
    for (int i = 0; i < `SWD_LIST_N; i++) begin
      ent.add_sel[i] = !ent.slot_on[i] && !found;
      found          = found | !ent.slot_on[i];
    end
  end

  // Entry table: eight slots plus the operational waveform.
  logic [`SWD_WFM_W-1:0] ent_wfm [`SWD_ENT_N];
  for (genvar i = 0; i < `SWD_LIST_N; i++) begin : g_ent
    assign ent.ent_on[i] = ent.slot_on[i];
    assign ent_wfm[i]    = ent.slot_wfm[i];
    assign ent.ent_y[i]  = first_y_reg[i];
  end
  assign ent.ent_on[`SWD_ENT_N-1] = !oper_in; // RULE11 RULE2
  assign ent_wfm[`SWD_ENT_N-1]    = OPER_WFM;
  assign ent.ent_y[`SWD_ENT_N-1]  = first_y_reg[`SWD_ENT_N-1];

  // Command decode on acceptance.
  wire logic acc    = CMD_VALID && CMD_READY;
  wire logic is_clr = CMD_CODE == SWD_CMD_CLEAR;
  wire logic is_rm  = CMD_CODE == SWD_CMD_REMOVE;
  wire logic is_add = CMD_CODE == SWD_CMD_ADD;
  wire logic is_ax  = CMD_CODE == SWD_CMD_AXIS;
  wire logic uses_x = is_rm || is_add || is_ax;
  wire logic bad_x  = uses_x && !in_range;
  wire logic add_go = acc && is_add && !bad_x && !any_hit && !full; // RULE8 RULE10
  wire logic rm_go  = acc && is_rm && !bad_x && any_hit; // RULE3
  wire logic ax_go  = acc && is_ax && !bad_x; // RULE17
  wire logic warn_next = acc && (bad_x || (is_rm && !any_hit) || // RULE5
                         (is_add && !any_hit && full)); // RULE10
  wire logic pop_next  = acc && uses_x; // RULE14 RULE3 RULE17

  assign ent.key     = x_round[`SWD_WFM_W-1:0];
  assign ent.clr_all = acc && is_clr; // RULE1
  assign ent.rm_stb  = rm_go;
  assign ent.add_stb = add_go; // RULE7

  // Commands are taken only between two drawn waveforms.
  assign CMD_READY = (c_st_reg == C_IDLE) && (d_st_reg == D_SEL);

  // Command sequencer: after each command, refresh first points and scale.
  always_comb begin
    c_st_next = c_st_reg;
    case (c_st_reg)
      C_IDLE: begin
        if (acc) begin
          c_st_next = C_RDF;
        end
      end
      C_RDF: c_st_next = C_CAPF;
      C_CAPF: begin
        if (r_idx_reg == `SWD_SRC_IDX) begin
          c_st_next = C_IDLE;
        end else begin
          c_st_next = C_RDF;
        end
      end
      default: c_st_next = C_IDLE;
    endcase
  end

  // Command state, mode settings and stack and warning pulses.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      c_st_reg  <= C_IDLE;
      r_idx_reg <= 4'h0;
      pop_reg   <= 1'b0;
      warn_reg  <= 1'b0;
      vec_reg   <= 1'b0;
      axis_reg  <= 1'b0;
      src_reg   <= '0;
    end else begin
      c_st_reg <= c_st_next;
      pop_reg  <= pop_next;
      warn_reg <= warn_next;
      if (c_st_reg == C_IDLE) begin
        r_idx_reg <= 4'h0;
      end else if (c_st_reg == C_CAPF) begin
        r_idx_reg <= r_idx_reg + 4'h1;
      end
      if (acc && (CMD_CODE == SWD_CMD_DOT)) begin
        vec_reg <= 1'b0; // RULE21
      end else if (acc && (CMD_CODE == SWD_CMD_VECTOR)) begin
        vec_reg <= 1'b1; // RULE21
      end
      if (acc && (CMD_CODE == SWD_CMD_TIME)) begin
        axis_reg <= 1'b0; // RULE21
      end else if (ax_go) begin
        axis_reg <= 1'b1; // RULE21
        src_reg  <= ent.key;
      end
    end
  end

  // Captured first points and the source waveform's vertical scale.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      first_y_reg   <= '{default: '0};
      src_scale_reg <= '0;
    end else if (c_st_reg == C_CAPF) begin
      if (r_idx_reg == `SWD_SRC_IDX) begin
        src_scale_reg <= MEM_VSCALE; // RULE20
      end else begin
        first_y_reg[r_idx_reg] <= MEM_DATA; // RULE13
      end
    end
  end

  // Readout line contents, in screen order.
  always_comb begin
    nums_next  = '0;
    count_next = 4'h0;
    for (int i = 0; i < `SWD_ENT_N; i++) begin
      if (ent.ent_on[i]) begin
        count_next = count_next + 4'h1;
        nums_next[ent.rank[i]*`SWD_WFM_W +: `SWD_WFM_W] = ent_wfm[i]; // RULE12 RULE13
      end
    end
  end

  // Readout registers and the reported horizontal scale.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      mnem_reg   <= SWD_LINE_LIST;
      count_reg  <= 4'h0;
      nums_reg   <= '0;
      hscale_reg <= '0;
    end else if (axis_reg) begin
      mnem_reg   <= SWD_LINE_AXIS; // RULE19
      count_reg  <= 4'h1;
      nums_reg   <= {{(8*`SWD_WFM_W){1'b0}}, src_reg};
      hscale_reg <= src_scale_reg; // RULE20
    end else begin
      mnem_reg   <= SWD_LINE_LIST; // RULE12
      count_reg  <= count_next;
      nums_reg   <= nums_next;
      hscale_reg <= TIME_HSCALE;
    end
  end

  // Drawing position: next entry, current point and its coordinates.
  wire logic [3:0] d_ent_inc = (d_ent_reg == `SWD_OPER_IDX) ? 4'h0 : d_ent_reg + 4'h1;
  wire logic       last_pt   = d_pt_reg == `SWD_LAST_PT;
  wire logic [2*`SWD_VAL_W-1:0] t_prod = $signed({7'h00, d_pt_reg}) * TIME_HINC;
  wire logic signed [`SWD_VAL_W-1:0] cur_x = axis_reg ? src_y_reg : // RULE18
                                             t_prod[`SWD_VAL_W-1:0]; // RULE15
  wire logic emit = !vec_reg || (d_pt_reg != '0); // RULE6 RULE16
  wire logic d_go = (c_st_reg == C_IDLE) && !CMD_VALID;

  // Drawing sequencer.
  always_comb begin
    d_st_next = d_st_reg;
    case (d_st_reg)
      D_SEL: begin
        if (d_go && ent.ent_on[d_ent_reg]) begin
          d_st_next = D_RDS;
        end
      end
      D_RDS:  d_st_next = D_CAPS;
      D_CAPS: d_st_next = D_RDP;
      D_RDP:  d_st_next = D_CAPP;
      D_CAPP: begin
        if (emit) begin
          d_st_next = D_WAIT;
        end else begin
          d_st_next = last_pt ? D_SEL : D_RDS;
        end
      end
      D_WAIT: begin
        if (DRAW_READY) begin
          d_st_next = last_pt ? D_SEL : D_RDS;
        end
      end
      default: d_st_next = D_SEL;
    endcase
  end

  // Drawing position registers.
  wire logic pt_done = ((d_st_reg == D_CAPP) && !emit) ||
                       ((d_st_reg == D_WAIT) && DRAW_READY);
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      d_st_reg  <= D_SEL;
      d_ent_reg <= 4'h0;
      d_pt_reg  <= '0;
      src_y_reg <= '0;
    end else begin
      d_st_reg <= d_st_next;
      if ((d_st_reg == D_SEL) && d_go && !ent.ent_on[d_ent_reg]) begin
        d_ent_reg <= d_ent_inc;
      end else if (pt_done && last_pt) begin
        d_ent_reg <= d_ent_inc;
      end
      if (d_st_reg == D_SEL) begin
        d_pt_reg <= '0;
      end else if (pt_done) begin
        d_pt_reg <= d_pt_reg + 9'h001;
      end
      if (d_st_reg == D_CAPS) begin
        src_y_reg <= MEM_DATA;
      end
    end
  end

  // Dot or segment output toward the display.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      dv_reg     <= 1'b0;
      dvec_reg   <= 1'b0;
      x0_reg     <= '0;
      y0_reg     <= '0;
      x1_reg     <= '0;
      y1_reg     <= '0;
      prev_x_reg <= '0;
      prev_y_reg <= '0;
    end else if (d_st_reg == D_CAPP) begin
      prev_x_reg <= cur_x;
      prev_y_reg <= MEM_DATA;
      dv_reg     <= emit;
      dvec_reg   <= vec_reg;
      x0_reg     <= vec_reg ? prev_x_reg : cur_x; // RULE16 RULE6
      y0_reg     <= vec_reg ? prev_y_reg : MEM_DATA;
      x1_reg     <= cur_x;
      y1_reg     <= MEM_DATA;
    end else if ((d_st_reg == D_WAIT) && DRAW_READY) begin
      dv_reg <= 1'b0;
    end
  end

  // Memory reads: refresh owns the port while the drawing waits in D_SEL.
  wire logic rd_c = c_st_reg == C_RDF;
  wire logic rd_s = d_st_reg == D_RDS;
  wire logic [`SWD_WFM_W-1:0] c_wfm = (r_idx_reg == `SWD_SRC_IDX) ? src_reg :
                                      ent_wfm[r_idx_reg];
  assign MEM_RD  = rd_c || rd_s || (d_st_reg == D_RDP);
  assign MEM_WFM = rd_c ? c_wfm : (rd_s ? src_reg : ent_wfm[d_ent_reg]);
  assign MEM_PT  = rd_c ? '0 : d_pt_reg;

  assign STACK_POP   = pop_reg;
  assign WARN        = warn_reg;
  assign DRAW_VALID  = dv_reg;
  assign DRAW_VEC    = dvec_reg;
  assign DRAW_X0     = x0_reg;
  assign DRAW_Y0     = y0_reg;
  assign DRAW_X1     = x1_reg;
  assign DRAW_Y1     = y1_reg;
  assign HSCALE      = hscale_reg;
  assign LINE2_MNEM  = mnem_reg;
  assign LINE2_COUNT = count_reg;
  assign LINE2_NUMS  = nums_reg;
  assign VEC_MODE    = vec_reg;
  assign AXIS_MODE   = axis_reg;
endmodule // swd_top
